// file: inc/calnv_pkg.sv
`default_nettype none
package calnv_pkg;
    typedef logic [7:0] calnv_byte_t;
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_SCAN,
        RD_WAIT,
        RD_DONE
    } calnv_rd_state_t;
endpackage : calnv_pkg
`default_nettype wire

// file: inc/calnv_regs.svh
`ifndef CALNV_REGS_SVH
`define CALNV_REGS_SVH

// information page indices (byte address on the bus is four times the index)
`define CALNV_IP_TEMP_HI 7'h3A
`define CALNV_IP_TEMP_LO 7'h3B
`define CALNV_IP_WDT_HI 7'h7E
`define CALNV_IP_WDT_LO 7'h7F
`define CALNV_IP_DEPTH 128

// converter calibration: page mapped at FE00, mode 0 locations below
`define CALNV_PAGE_BASE 16'hFE00
`define CALNV_CONV0_OFS 16'hFE60
`define CALNV_CONV0_GAIN_HI 16'hFE08
`define CALNV_CONV0_GAIN_LO 16'hFE09
`define CALNV_CONV_MODES 4'hA
`define CALNV_CONV_OFS_STEP 7'h03
`define CALNV_CONV_GAIN_STEP 7'h02

// control and result registers, byte addresses
`define CALNV_A_READ 16'h1000
`define CALNV_A_RESULT 16'h1004
`define CALNV_A_STATUS 16'h1008
`define CALNV_A_WRITE 16'h100C
`define CALNV_A_ERASE 16'h1010
`define CALNV_A_TEMP 16'h1014
`define CALNV_A_WDT 16'h1018
`define CALNV_A_CONV_SEL 16'h101C
`define CALNV_A_CONV_CAL 16'h1020
`define CALNV_A_IP_TOP 16'h01FF

// reset values and answer codes
`define CALNV_CONV_SEL_RST 4'h0
`define CALNV_WDT_UPPER 8'h00
`define CALNV_ILLEGAL_DATA 8'hFF
`define CALNV_ERASED_DATA 8'hFF
`define CALNV_STATUS_OK 8'h00
`define CALNV_STATUS_CRC 8'h01
`define CALNV_STATUS_ILLEGAL 8'h80
`define CALNV_CRC_POLY 8'h07

// timing, figures at the reference clock; cycle counts derived in code
`define CALNV_REF_MHZ 20
`define CALNV_READ_MIN_US 44
`define CALNV_READ_MAX_US 489
`define CALNV_ILLEGAL_US 2
`define CALNV_STEP_NS 500
`define CALNV_EXTRA_CAP_US 511

`endif

// file: logic/calnv_store.sv
`include "calnv_regs.svh"
`default_nettype none
module calnv_store #(
    parameter int DEPTH = 128
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_go,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic erase_go,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic rd_valid,
    output logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_crc_ok,
    output logic [$clog2(DEPTH+1)-1:0] count,
    output logic full,
    output logic wr_busy
);
    localparam int IW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] crc8(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] c;
        logic [15:0] m;
        c = 8'h00;
        m = {a, d};
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ m[i]) begin
                c = {c[6:0], 1'b0} ^ `CALNV_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : crc8

    ////////////////////////////////////////////////////////////////////////
    // log entries are nonvolatile: no reset touches them
    logic ent_valid [0:DEPTH-1];
    logic [7:0] ent_addr [0:DEPTH-1];
    logic [7:0] ent_data [0:DEPTH-1];
    logic [7:0] ent_crc [0:DEPTH-1];
    logic [CW-1:0] count_q;
    logic [IW-1:0] slot_q;
    logic wr_phase_q;

    // commit phase flag, dropped by reset so an interrupted write stays bad
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_phase_q <= 1'b0;
        end else begin
            wr_phase_q <= wr_go;
        end
    end

    // append: data first with a poisoned check byte, check byte one cycle later
    always_ff @(posedge clk) begin
        if (erase_go) begin
            count_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                ent_valid[i] <= 1'b0;
            end
        end else if (wr_go) begin
            slot_q <= count_q[IW-1:0];
            count_q <= count_q + CW'(1);
            ent_valid[count_q[IW-1:0]] <= 1'b1;
            ent_addr[count_q[IW-1:0]] <= wr_addr;
            ent_data[count_q[IW-1:0]] <= wr_data;
            ent_crc[count_q[IW-1:0]] <= ~crc8(wr_addr, wr_data);
        end else if (wr_phase_q) begin
            ent_crc[slot_q] <= crc8(ent_addr[slot_q], ent_data[slot_q]);
        end
    end

    // older entries are never rewritten, only the newest slot is at risk
    assign rd_valid = ent_valid[rd_idx];
    assign rd_addr = ent_addr[rd_idx];
    assign rd_data = ent_data[rd_idx];
    assign rd_crc_ok = (ent_crc[rd_idx] == crc8(ent_addr[rd_idx], ent_data[rd_idx]));
    assign count = count_q;
    assign full = (count_q == CW'(DEPTH));
    assign wr_busy = wr_phase_q;

    ////////////////////////////////////////////////////////////////////////
    a_commit_crc: assert property (@(posedge clk) disable iff (!arst_n)
        wr_phase_q && !erase_go |=> ent_crc[$past(slot_q)] ==
        crc8(ent_addr[$past(slot_q)], ent_data[$past(slot_q)]))
        else $error("check byte not committed after write");
endmodule : calnv_store
`default_nettype wire

// file: logic/calnv_top.sv
// Chosen here: the APB slave port.
`include "calnv_regs.svh"
`default_nettype none
module calnv_top #(
    parameter int STORE_SIZE = 64,
    parameter int LOG_DEPTH = 128,
    parameter int READ_MAX_CYC = `CALNV_READ_MAX_US * `CALNV_REF_MHZ
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rd_req,
    input wire logic [7:0] rd_addr,
    output logic rd_done,
    output logic rd_busy,
    output logic [7:0] rd_data,
    output logic [7:0] rd_status
);
    localparam int IW = $clog2(LOG_DEPTH);
    localparam int CW = $clog2(LOG_DEPTH+1);
    localparam int MIN_CYC = `CALNV_READ_MIN_US * `CALNV_REF_MHZ;
    localparam int ILLEGAL_CYC = `CALNV_ILLEGAL_US * `CALNV_REF_MHZ;
    localparam int STEP_CYC = (`CALNV_STEP_NS * `CALNV_REF_MHZ + 999) / 1000;
    localparam int CAP_CYC = (`CALNV_EXTRA_CAP_US - STORE_SIZE) * `CALNV_REF_MHZ;

    ////////////////////////////////////////////////////////////////////////
    // bus decode helpers
    function automatic logic is_page(input logic [15:0] a);
        return (a <= `CALNV_A_IP_TOP);
    endfunction : is_page

    function automatic logic addr_ok(input logic [15:0] a);
        logic ok;
        ok = 1'b0;
        if (a[1:0] == 2'b00) begin
            ok = is_page(a) || (a >= `CALNV_A_READ && a <= `CALNV_A_CONV_CAL);
        end
        return ok;
    endfunction : addr_ok

    function automatic logic [6:0] page_idx(input logic [15:0] mem);
        return 7'(mem - `CALNV_PAGE_BASE);
    endfunction : page_idx

    ////////////////////////////////////////////////////////////////////////
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic acc;
    logic wr_acc;

    // zero wait states: ready rises at the edge that ends the setup cycle, high for the one access cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= psel && !penable && !pready_q;
        end
    end

    assign acc = psel && penable && pready_q;
    assign wr_acc = acc && pwrite && addr_ok(paddr);

    ////////////////////////////////////////////////////////////////////////
    // information page, kept across reset on purpose
    logic [7:0] info_mem [0:`CALNV_IP_DEPTH-1];

    always_ff @(posedge clk) begin
        if (wr_acc && is_page(paddr)) begin
            info_mem[paddr[8:2]] <= pwdata[7:0];
        end
    end

    // converter mode select, out-of-range modes are dropped
    logic [3:0] conv_sel_q;
    logic [6:0] conv_ofs_idx;
    logic [6:0] conv_gh_idx;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conv_sel_q <= `CALNV_CONV_SEL_RST;
        end else if (wr_acc && paddr == `CALNV_A_CONV_SEL &&
                     pwdata[3:0] < `CALNV_CONV_MODES) begin
            conv_sel_q <= pwdata[3:0];
        end
    end

    // offsets step by three, gain pairs by two, from the mode 0 spots
    assign conv_ofs_idx = 7'(page_idx(`CALNV_CONV0_OFS) +
                             7'(conv_sel_q) * `CALNV_CONV_OFS_STEP);
    assign conv_gh_idx = 7'(page_idx(`CALNV_CONV0_GAIN_HI) +
                            7'(conv_sel_q) * `CALNV_CONV_GAIN_STEP);

    ////////////////////////////////////////////////////////////////////////
    // store and read engine
    calnv_pkg::calnv_rd_state_t state_q;
    logic [7:0] addr_q;
    logic [IW-1:0] idx_q;
    logic [CW-1:0] scanned_q;
    logic [13:0] elapsed_q;
    logic [13:0] target_w;
    logic illegal_q;
    logic found_q;
    logic bad_q;
    logic [7:0] hit_q;
    logic rd_done_q;
    logic rd_busy_q;
    logic [7:0] rd_data_q;
    logic [7:0] rd_status_q;
    logic e_valid;
    logic [7:0] e_addr;
    logic [7:0] e_data;
    logic e_ok;
    logic [CW-1:0] count;
    logic full;
    logic wr_busy;
    logic store_wr;
    logic store_erase;
    logic can_start;
    logic start_bus;
    logic start_hw;
    logic [7:0] start_addr;
    logic hit;

    // store writes and erase only while no read is in flight
    assign store_wr = wr_acc && paddr == `CALNV_A_WRITE && state_q == calnv_pkg::RD_IDLE &&
                      !full && !wr_busy;
    assign store_erase = wr_acc && paddr == `CALNV_A_ERASE && state_q == calnv_pkg::RD_IDLE &&
                         !wr_busy;

    calnv_store #(
        .DEPTH(LOG_DEPTH)
    ) u_store (
        .clk(clk),
        .arst_n(arst_n),
        .wr_go(store_wr),
        .wr_addr(pwdata[15:8]),
        .wr_data(pwdata[7:0]),
        .erase_go(store_erase),
        .rd_idx(idx_q),
        .rd_valid(e_valid),
        .rd_addr(e_addr),
        .rd_data(e_data),
        .rd_crc_ok(e_ok),
        .count(count),
        .full(full),
        .wr_busy(wr_busy)
    );

    // bus launch at the entry address wins over the hardware strobe
    assign can_start = state_q == calnv_pkg::RD_IDLE && !wr_busy;
    assign start_bus = can_start && wr_acc && paddr == `CALNV_A_READ;
    assign start_hw = can_start && !start_bus && rd_req;
    assign start_addr = start_bus ? pwdata[7:0] : rd_addr;
    assign hit = e_valid && e_addr == addr_q;

    // completion time: fixed base plus a step per entry walked and per write
    always_comb begin
        int extra;
        int total;
        extra = 0;
        total = 0;
        extra = (int'(scanned_q) + int'(count)) * STEP_CYC;
        if (extra > CAP_CYC) begin
            extra = CAP_CYC;
        end
        total = MIN_CYC + extra;
        if (total > READ_MAX_CYC) begin
            total = READ_MAX_CYC;
        end
        target_w = illegal_q ? 14'(ILLEGAL_CYC) : 14'(total);
    end

    // walk the log from newest to oldest, first good match ends the walk
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= calnv_pkg::RD_IDLE;
            addr_q <= 8'h00;
            idx_q <= '0;
            scanned_q <= '0;
            elapsed_q <= 14'h0000;
            illegal_q <= 1'b0;
            found_q <= 1'b0;
            bad_q <= 1'b0;
            hit_q <= 8'h00;
        end else begin
            case (state_q)
                calnv_pkg::RD_IDLE: begin
                    if (start_bus || start_hw) begin
                        addr_q <= start_addr;
                        elapsed_q <= 14'h0001;
                        scanned_q <= '0;
                        found_q <= 1'b0;
                        bad_q <= 1'b0;
                        hit_q <= `CALNV_ERASED_DATA;
                        idx_q <= IW'(count - CW'(1));
                        illegal_q <= (32'(start_addr) >= STORE_SIZE);
                        if (32'(start_addr) >= STORE_SIZE || count == '0) begin
                            state_q <= calnv_pkg::RD_WAIT;
                        end else begin
                            state_q <= calnv_pkg::RD_SCAN;
                        end
                    end
                end
                calnv_pkg::RD_SCAN: begin
                    elapsed_q <= elapsed_q + 14'h0001;
                    scanned_q <= scanned_q + CW'(1);
                    if (hit && e_ok) begin
                        found_q <= 1'b1;
                        hit_q <= e_data;
                    end else if (hit) begin
                        bad_q <= 1'b1;
                    end
                    if ((hit && e_ok) || idx_q == '0) begin
                        state_q <= calnv_pkg::RD_WAIT;
                    end else begin
                        idx_q <= idx_q - IW'(1);
                    end
                end
                calnv_pkg::RD_WAIT: begin
                    elapsed_q <= elapsed_q + 14'h0001;
                    if (elapsed_q + 14'h0001 >= target_w) begin
                        state_q <= calnv_pkg::RD_DONE;
                    end
                end
                calnv_pkg::RD_DONE: begin
                    state_q <= calnv_pkg::RD_IDLE;
                end
                default: begin
                    state_q <= calnv_pkg::RD_IDLE;
                end
            endcase
        end
    end

    // results stay in dedicated flops, the caller lends no memory
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_done_q <= 1'b0;
            rd_busy_q <= 1'b0;
            rd_data_q <= 8'h00;
            rd_status_q <= `CALNV_STATUS_OK;
        end else begin
            rd_done_q <= 1'b0;
            if (start_bus || start_hw) begin
                rd_busy_q <= 1'b1;
            end
            if (state_q == calnv_pkg::RD_WAIT && elapsed_q + 14'h0001 >= target_w) begin
                rd_done_q <= 1'b1;
                rd_busy_q <= 1'b0;
                if (illegal_q) begin
                    rd_data_q <= `CALNV_ILLEGAL_DATA;
                    rd_status_q <= `CALNV_STATUS_ILLEGAL;
                end else begin
                    rd_data_q <= hit_q;
                    rd_status_q <= bad_q ? `CALNV_STATUS_CRC : `CALNV_STATUS_OK;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read-back mux, sampled in the setup cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_q <= !addr_ok(paddr);
            prdata_q <= 32'h0000_0000;
            if (is_page(paddr)) begin
                prdata_q <= {24'h00_0000, info_mem[paddr[8:2]]};
            end else begin
                case (paddr)
                    `CALNV_A_READ: prdata_q <= {31'h0000_0000, rd_busy_q};
                    `CALNV_A_RESULT: prdata_q <= {24'h00_0000, rd_data_q};
                    `CALNV_A_STATUS: prdata_q <= {24'h00_0000, rd_status_q};
                    `CALNV_A_WRITE: prdata_q <= {30'h0000_0000, wr_busy, full};
                    `CALNV_A_ERASE: prdata_q <= 32'(count);
                    `CALNV_A_TEMP: prdata_q <= {20'h0_0000, info_mem[`CALNV_IP_TEMP_HI],
                                                info_mem[`CALNV_IP_TEMP_LO][7:4]};
                    `CALNV_A_WDT: prdata_q <= {8'h00, `CALNV_WDT_UPPER,
                                               info_mem[`CALNV_IP_WDT_HI],
                                               info_mem[`CALNV_IP_WDT_LO]};
                    `CALNV_A_CONV_SEL: prdata_q <= {28'h000_0000, conv_sel_q};
                    `CALNV_A_CONV_CAL: prdata_q <= {8'h00, info_mem[conv_ofs_idx],
                                                    info_mem[conv_gh_idx],
                                                    info_mem[7'(conv_gh_idx + 7'h01)]};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rd_done = rd_done_q;
    assign rd_busy = rd_busy_q;
    assign rd_data = rd_data_q;
    assign rd_status = rd_status_q;

    ////////////////////////////////////////////////////////////////////////
    a_done_one_cycle: assert property (@(posedge clk) disable iff (!arst_n)
        rd_done_q |=> !rd_done_q && !rd_busy_q)
        else $error("done not a single pulse");
    a_illegal_data: assert property (@(posedge clk) disable iff (!arst_n)
        rd_done_q && illegal_q |-> rd_data_q == `CALNV_ILLEGAL_DATA)
        else $error("illegal read did not return ff");
    a_illegal_time: assert property (@(posedge clk) disable iff (!arst_n)
        rd_done_q && illegal_q |-> elapsed_q == 14'(ILLEGAL_CYC))
        else $error("illegal read took wrong time");
    a_read_min_time: assert property (@(posedge clk) disable iff (!arst_n)
        rd_done_q && !illegal_q |-> elapsed_q >= 14'(MIN_CYC))
        else $error("valid read finished too early");
    a_read_max_time: assert property (@(posedge clk) disable iff (!arst_n)
        rd_done_q |-> elapsed_q <= 14'(READ_MAX_CYC))
        else $error("read finished too late");
    a_time_target: assert property (@(posedge clk) disable iff (!arst_n)
        rd_done_q |-> elapsed_q == target_w && $past(state_q) == calnv_pkg::RD_WAIT)
        else $error("read time does not match its target");
    a_status_good: assert property (@(posedge clk) disable iff (!arst_n)
        rd_done_q && !illegal_q |-> (rd_status_q == `CALNV_STATUS_OK) == !bad_q)
        else $error("status does not follow check result");
    a_status_data: assert property (@(posedge clk) disable iff (!arst_n)
        rd_done_q && !illegal_q && found_q |-> rd_data_q == hit_q)
        else $error("good entry data not returned");
    a_apb_ready: assert property (@(posedge clk) disable iff (!arst_n)
        psel && !penable && !pready_q |=> pready_q ##1 !pready_q)
        else $error("bus answer not one cycle after setup");
    a_conv_select: assert property (@(posedge clk) disable iff (!arst_n)
        wr_acc && paddr == `CALNV_A_CONV_SEL && pwdata[3:0] < `CALNV_CONV_MODES
        |=> conv_sel_q == $past(pwdata[3:0]))
        else $error("converter mode select not taken");
endmodule : calnv_top
`default_nettype wire

// file: tb/calibration_byte_store_read_test.sv
`default_nettype none
module calibration_byte_store_read_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0, pready, pslverr;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic [7:0] go_addr = 8'h00, a, d, s, rd_data, rd_status, rd_addr, pg [128];
    logic rd_req, rd_done, rd_busy, e;
    logic [16:0] log_q [$]; // {check good, address, data}, newest last
    int errors = 0, compares = 0, t;
    always #50 clk = ~clk;
    calnv_top #(.READ_MAX_CYC(2000)) i_calnv_top (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_done(rd_done), .rd_busy(rd_busy), .rd_data(rd_data), .rd_status(rd_status));
    calnv_sw_model i_calnv_sw_model (.clk(clk), .arst_n(arst_n), .go(go), .go_addr(go_addr),
        .rd_done(rd_done), .rd_req(rd_req), .rd_addr(rd_addr));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] ad, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pw(input logic [6:0] i, input logic [7:0] v);
        pg[i] = v;
        apb(1'b1, {7'h00, i, 2'b00}, {24'h0, v});
    endtask : pw
    // expected store answer: walk newest first until a good match
    task automatic mdl(input logic [7:0] ad);
        int sw;
        sw = 0;
        d = 8'hFF;
        s = 8'h00;
        for (int i = log_q.size() - 1; i >= 0; i--) begin
            sw++;
            if (log_q[i][15:8] == ad && log_q[i][16]) break;
            if (log_q[i][15:8] == ad) s = 8'h01;
        end
        if (sw > 0 && log_q[log_q.size() - sw][15:8] == ad) d = log_q[log_q.size() - sw][7:0];
        if (d != 8'hFF && !log_q[log_q.size() - sw][16]) d = 8'hFF;
        t = (sw + log_q.size()) * 10;
        t = 880 + (t < 8940 ? t : 8940);
        t = (t < 2000) ? t : 2000;
        if (ad >= 8'd64) t = 40;
    endtask : mdl
    task automatic sread(input logic [7:0] ad, input bit timed);
        int n;
        n = 0;
        mdl(ad);
        @(posedge clk);
        go <= 1'b1;
        go_addr <= ad;
        @(posedge clk);
        go <= 1'b0;
        // n counts edges from the taking one up to done, both ends included
        do begin
            @(posedge clk);
            #1 n++;
            if (n == 1) chk("rd_busy", 1, rd_busy);
        end while (rd_done !== 1'b1);
        chk("rd_busy", 0, rd_busy);
        chk("rd_data", {24'h0, d}, {24'h0, rd_data});
        if (ad < 8'd64) chk("rd_status", {24'h0, s}, {24'h0, rd_status});
        if (timed) chk("read time", t, n);
        repeat (2) @(posedge clk);
    endtask : sread
    // read launched over the bus, answer fetched from the result registers
    task automatic bread(input logic [7:0] ad);
        mdl(ad);
        apb(1'b1, 16'h1000, {24'h0, ad});
        do begin
            apb(1'b0, 16'h1000, 0);
        end while (r[0] !== 1'b0);
        apb(1'b0, 16'h1004, 0);
        chk("bus rd_data", {24'h0, d}, r);
        apb(1'b0, 16'h1008, 0);
        chk("bus rd_status", {24'h0, s}, r);
    endtask : bread
    task automatic swr(input logic [7:0] ad, input logic [7:0] v, input bit cut);
        apb(1'b1, 16'h100C, {16'h0, ad, v});
        log_q.push_back({~cut, ad, v});
        if (cut) arst_n <= 1'b0; // reset lands inside the commit
        @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
    endtask : swr
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        void'($urandom(32'hcd4e54e3));
        for (int m = 0; m < 10; m++) begin
            pw(7'(7'h60 + 3 * m), 8'($urandom));
            pw(7'(7'h08 + 2 * m), 8'($urandom));
            pw(7'(7'h09 + 2 * m), 8'($urandom));
            apb(1'b1, 16'h101C, m);
            apb(1'b0, 16'h1020, 0);
            chk("conv cal", {8'h0, pg[7'h60 + 3 * m], pg[7'h08 + 2 * m], pg[7'h09 + 2 * m]},
                r);
        end
        apb(1'b1, 16'h101C, 10);
        apb(1'b0, 16'h101C, 0);
        chk("conv sel", 9, r);
        pw(7'h3A, 8'($urandom));
        pw(7'h3B, 8'($urandom));
        pw(7'h7E, 8'($urandom));
        pw(7'h7F, 8'($urandom));
        apb(1'b0, 16'h1024, 0);
        chk("unmapped err", 1, {31'h0, e});
        $display("test page done");
        for (int k = 0; k < 2; k++) begin
            // reset first, so the mode select is back at mode 0 for the check
            @(posedge clk);
            arst_n <= 1'b0;
            @(posedge clk);
            arst_n <= 1'b1;
            apb(1'b0, 16'h1014, 0);
            chk("temp cal", {20'h0, pg[7'h3A], pg[7'h3B][7:4]}, r);
            apb(1'b0, 16'h1018, 0);
            chk("wdt cal", {16'h0, pg[7'h7E], pg[7'h7F]}, r);
            apb(1'b0, 16'h1020, 0);
            chk("conv after", {8'h0, pg[7'h60], pg[7'h08], pg[7'h09]}, r);
        end
        $display("test reset keep done");
        apb(1'b1, 16'h1010, 0);
        sread(8'h50, 1'b1);
        sread(8'h05, 1'b1);
        $display("test blank done");
        for (int k = 0; k < 5; k++) begin
            a = (k < 3) ? 8'($urandom % 60) : 8'h3F;
            swr(a, 8'($urandom), 1'b0);
            sread(a, 1'b1);
        end
        sread(8'h3E, 1'b1);
        bread(8'h3F);
        apb(1'b0, 16'h1010, 0);
        chk("log count", log_q.size(), r);
        apb(1'b0, 16'h100C, 0);
        chk("store flags", 0, r);
        $display("test store done");
        swr(8'h3F, 8'h5A, 1'b1);
        sread(8'h3F, 1'b0);
        sread(log_q[0][15:8], 1'b0);
        $display("test cut write done");
        tally_and_finish();
    end
endmodule : calibration_byte_store_read_test
`default_nettype wire

// file: tb/calnv_sw_model.sv
`default_nettype none
module calnv_sw_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic [7:0] go_addr,
    input wire logic rd_done,
    output logic rd_req,
    output logic [7:0] rd_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    // caller holds the request until done; the released address is inverted, never left stale
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_req <= 1'b0;
            rd_addr <= 8'h00;
        end else if (go) begin
            rd_req <= 1'b1;
            rd_addr <= go_addr;
        end else if (rd_req && rd_done) begin
            rd_req <= 1'b0;
            rd_addr <= ~rd_addr;
        end
    end
endmodule : calnv_sw_model
`default_nettype wire
